// File: dv/hot_plug_turn_on_sequencer_test.sv
module hot_plug_turn_on_sequencer_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int QUAL = 20;
	logic        mclk = 1'b0;
	logic        resetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, er;
	logic        bsel_n = 1'b1, pin = 1'b0, ils_ok = 1'b0, pci_rst_n = 1'b0, dsg = 1'b1;
	logic [2:0]  uv_ok = 3'h7;
	logic [3:0]  clim = 4'h0, aol = 4'h0, gate_on, arm;
	logic        t100, t10, t2, tdis, s20, s2, ssr, pg_n, lrst_n, thi, tlo, good;
	int          n_fail = 0, compares = 0;

	// The clock runs at 25 MHz.
	always #20 mclk = ~mclk;

	hps_sequencer #(.QUAL_CYCLES(QUAL)) i_dut (
		.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.board_select_n(bsel_n), .turn_on_pin(pin), .internal_low_supply_ok(ils_ok),
		.input_uv_ok(uv_ok), .vee_uv_ok(1'b1), .cfg_tied_low(1'b1), .supply_uv_event(1'b0),
		.breaker_trip(4'h0), .current_limit(clim), .amp_open_loop(aol), .outputs_good(good),
		.downstream_good_in(dsg), .pci_reset_n(pci_rst_n), .timer_hi(thi), .timer_lo(tlo),
		.gate_on(gate_on), .breaker_arm(arm), .timer_src_100u(t100), .timer_src_10u(t10),
		.timer_src_2u(t2), .timer_discharge(tdis), .ss_src_20u(s20), .ss_src_2u(s2),
		.ss_reset(ssr), .power_good_out_n(pg_n), .local_bus_reset_n(lrst_n));

	hps_plant i_plant (.mclk(mclk), .gate_on(gate_on), .src_on(t100 | t10 | t2),
		.discharge(tdis), .timer_hi(thi), .timer_lo(tlo), .outputs_good(good));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %0t %s got %0h want %0h", $time, what, got, exp);
		end
	endtask

	// One APB transfer; the request is held until pready is seen at an edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the answer.
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_for(input logic sel_arm, input logic [3:0] v);
		int n;
		n = 0;
		while ((sel_arm ? arm : gate_on) !== v && n < 200) begin
			@(posedge mclk);
			n++;
		end
		chk(sel_arm ? arm : gate_on, v, "gate or breaker");
	endtask

	task automatic wait_state(input logic [3:0] s);
		int n;
		n = 0;
		do begin
			apb(1'b0, 8'h0C, 32'h0);
			n++;
		end while (rd[3:0] !== s && n < 40);
		chk(rd[3:0], s, "state");
	endtask

	task automatic s_regs();
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0, "control reset");
		apb(1'b0, 8'h10, 32'h0);
		chk({er, rd}, {1'b1, 32'h0}, "unmapped");
	endtask

	task automatic s_qual();
		ils_ok <= 1'b1;
		pin <= 1'b1;
		repeat (40) @(posedge mclk);
		chk({gate_on, lrst_n}, 5'h00, "early insertion");
		bsel_n <= 1'b0;
		repeat (QUAL - 5) @(posedge mclk);
		uv_ok <= 3'h5;
		@(posedge mclk);
		uv_ok <= 3'h7;
		repeat (QUAL - 5) @(posedge mclk);
		chk(gate_on, 4'h0, "qual restart");
		wait_for(1'b0, 4'hF);
		@(posedge mclk);
		chk({t100, s20, ssr}, 3'b110, "ramp sources");
		while (thi !== 1'b1) @(posedge mclk);
		@(posedge mclk);
		chk(tdis, 1'b1, "timer discharge");
		wait_for(1'b1, 4'hF);
		chk(ssr, 1'b1, "soft-start reset");
		repeat (3) @(posedge mclk);
		chk(pg_n, 1'b0, "power good");
		chk({t10, tdis}, 2'b10, "timeout source");
		pci_rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		chk(lrst_n, 1'b1, "bus reset follows");
		wait_state(4'h5);
	endtask

	task automatic s_seq();
		pin <= 1'b0;
		repeat (2) @(posedge mclk);
		chk(gate_on, 4'h0, "pin off");
		apb(1'b1, 8'h00, 32'h1);
		aol <= 4'h1;
		pin <= 1'b1;
		wait_for(1'b0, 4'h1);
		@(posedge mclk);
		chk({s20, s2}, 2'b01, "slow soft-start");
		aol <= 4'h0;
		wait_for(1'b0, 4'h3);
		wait_for(1'b0, 4'h7);
		wait_for(1'b0, 4'hF);
		wait_state(4'h5);
		dsg <= 1'b0;
		wait_for(1'b0, 4'h0);
		dsg <= 1'b1;
		apb(1'b0, 8'h08, 32'h0);
		chk(rd[2:0], 3'h4, "downstream fault logged");
		wait_state(4'h0);
		apb(1'b1, 8'h08, 32'h0);
	endtask

	// Command start, a start-up into a limit, fault clear and power-on clear.
	task automatic s_cmd();
		pin <= 1'b0;
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b1, 8'h04, 32'h1);
		wait_for(1'b1, 4'h1);
		repeat (20) @(posedge mclk);
		chk(gate_on, 4'h1, "idle");
		clim <= 4'h2;
		apb(1'b1, 8'h04, 32'h3);
		repeat (4) @(posedge mclk);
		chk(gate_on, 4'h3, "limit ignored");
		wait_for(1'b0, 4'h0);
		@(posedge mclk);
		chk(t2, 1'b1, "cool-down");
		clim <= 4'h0;
		apb(1'b0, 8'h08, 32'h0);
		chk(rd[2:0], 3'h2, "overcurrent logged");
		wait_state(4'h0);
		apb(1'b1, 8'h08, 32'h0);
		apb(1'b0, 8'h08, 32'h0);
		chk(rd[2:0], 3'h0, "fault cleared");
		apb(1'b1, 8'h00, 32'h1);
		ils_ok <= 1'b0;
		@(posedge mclk);
		ils_ok <= 1'b1;
		repeat (2) @(posedge mclk);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0, "power-on clear");
	endtask

	task automatic give_verdict();
		if (n_fail == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// The whole run needs a few hundred cycles; this limit is far beyond.
	initial begin
		repeat (20000) @(posedge mclk);
		n_fail++;
		give_verdict();
	end

	initial begin
		repeat (6) @(posedge mclk);
		resetn <= 1'b1;
		s_regs();
		s_qual();
		s_seq();
		s_cmd();
		give_verdict();
	end
endmodule

// File: dv/hps_plant.sv
module hps_plant #(
	parameter int HI = 8  // Timer steps up to the high level.
) (
	input  wire logic       mclk,         // System clock.
	input  wire logic [3:0] gate_on,      // Gate drives.
	input  wire logic       src_on,       // Any timer source on.
	input  wire logic       discharge,    // Timer switch to ground.
	output logic            timer_hi,     // Timer at high level.
	output logic            timer_lo,     // Timer below low level.
	output logic            outputs_good  // All outputs in tolerance.
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] lvl = 8'h00;

	// The switch to ground wins, so a source left on cannot hide a discharge.
	always @(posedge mclk) begin
		if (discharge)
			lvl <= 8'h00;
		else if (src_on && lvl < 8'(HI))
			lvl <= lvl + 8'h01;
	end

	// Outputs only settle behind gates that are on.
	assign timer_hi = (lvl >= 8'(HI));
	assign timer_lo = (lvl < 8'h02);
	assign outputs_good = &gate_on;
endmodule

// File: logic/hps_apb_regs.sv
`include "hps_cfg.svh"

module hps_apb_regs import hps_pkg::*; (
	input  wire logic        mclk,     // System clock.
	input  wire logic        resetn,   // Synchronous reset, active low.
	input  wire logic        psel,     // APB select.
	input  wire logic        penable,  // APB access phase.
	input  wire logic        pwrite,   // APB direction.
	input  wire logic [7:0]  paddr,    // APB byte address.
	input  wire logic [31:0] pwdata,   // APB write data.
	output logic      [31:0] prdata,   // APB read data.
	output logic             pready,   // APB ready.
	output logic             pslverr,  // APB error for unmapped offsets.
	hps_reg_if.regs          rif       // Control and status toward the core.
);
	typedef struct packed {
		logic [3:0]  ctrl;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} hps_apb_t;

	hps_apb_t s;
	hps_apb_t next_s;
	logic     wr;

	// A write lands only at the edge where the access phase sees pready.
	assign wr = psel && penable && pready && pwrite;
	assign rif.on_wr = wr && (paddr == `HPS_OFF_ON);
	assign rif.fault_wr = wr && (paddr == `HPS_OFF_FAULT);
	assign rif.wdata = pwdata[3:0];
	assign rif.seq_en = s.ctrl[`HPS_CTRL_SEQ];
	assign rif.retry = s.ctrl[`HPS_CTRL_RETRY +: 3];

	// Zero-wait slave: decode in setup, answer in the first access cycle.
	always_comb begin
		next_s = s;
		next_s.pready = 1'b0;
		next_s.pslverr = 1'b0;
		if (psel && !penable) begin
			next_s.pready = 1'b1;
			case (paddr)
				`HPS_OFF_CTRL: next_s.prdata = {28'h0000000, s.ctrl};
				`HPS_OFF_ON: next_s.prdata = {24'h000000, rif.on_stat, rif.on_ctrl};
				`HPS_OFF_FAULT: next_s.prdata = {29'h00000000, rif.fault};
				`HPS_OFF_STAT: next_s.prdata = {25'h0000000, rif.pg_ok, rif.qualified,
					rif.busy, rif.st};
				default: begin
					next_s.prdata = 32'h00000000;
					next_s.pslverr = 1'b1;
				end
			endcase
		end
		if (wr && paddr == `HPS_OFF_CTRL) begin
			next_s.ctrl = pwdata[3:0];
		end
		if (rif.por) begin
			next_s.ctrl = `HPS_CTRL_RST;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;

	a_apb_ready: assert property (@(posedge mclk) disable iff (!resetn)
		psel && !penable |=> pready) else $error("setup not answered next cycle");
endmodule

// File: logic/hps_cfg.svh
`ifndef HPS_CFG_SVH
`define HPS_CFG_SVH

// Qualification hold time and the cycle count it takes at the system clock.
`define HPS_QUAL_TIME_MS  100
`define HPS_CLK_KHZ       25000
`define HPS_QUAL_CYCLES   (`HPS_QUAL_TIME_MS * `HPS_CLK_KHZ)

// Register byte offsets.
`define HPS_OFF_CTRL      8'h00
`define HPS_OFF_ON        8'h04
`define HPS_OFF_FAULT     8'h08
`define HPS_OFF_STAT      8'h0C

// Control register fields and reset value.
`define HPS_CTRL_SEQ      0
`define HPS_CTRL_RETRY    1
`define HPS_CTRL_RST      4'h0

// Fault register fields.
`define HPS_FLT_UV        0
`define HPS_FLT_OC        1
`define HPS_FLT_PG        2

// First on-control bits set by the turn-on pin.
`define HPS_FIRST_SEQ     4'h1
`define HPS_FIRST_ALL     4'hF

`endif

// File: logic/hps_pkg.sv
package hps_pkg;

	typedef enum logic [3:0] {
		HPS_READY    = 4'b0000,
		HPS_RAMP_CHG = 4'b0001,
		HPS_RAMP_DIS = 4'b0010,
		HPS_PGI_CHG  = 4'b0011,
		HPS_PGI_DIS  = 4'b0100,
		HPS_RUN      = 4'b0101,
		HPS_COOL_CHG = 4'b0110,
		HPS_COOL_DIS = 4'b0111
	} hps_state_t;

	typedef struct packed {
		logic [3:0] gate_on;
		logic [3:0] breaker_arm;
		logic       tmr_100u;
		logic       tmr_10u;
		logic       tmr_2u;
		logic       tmr_dis;
		logic       ss_20u;
		logic       ss_2u;
		logic       ss_rst;
		logic       pg_n;
		logic       lrst_n;
	} hps_out_t;

endpackage

// File: logic/hps_qual_timer.sv
`include "hps_cfg.svh"

module hps_qual_timer import hps_pkg::*; #(
	parameter int CYCLES = `HPS_QUAL_CYCLES
) (
	input  wire logic mclk,    // System clock.
	input  wire logic resetn,  // Synchronous reset, active low.
	input  wire logic ok,      // All start conditions present.
	output logic      done     // Conditions held for the full interval.
);
	localparam int CW = $clog2(CYCLES + 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          done;
	} hps_qt_t;

	hps_qt_t s;
	hps_qt_t next_s;

	// Saturating count that starts over whenever a condition drops.
	always_comb begin
		next_s = s;
		if (!ok) begin
			next_s.cnt = '0;
		end else if (s.cnt != CW'(CYCLES - 1)) begin
			next_s.cnt = s.cnt + CW'(1);
		end
		next_s.done = ok && (s.cnt == CW'(CYCLES - 1));
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign done = s.done;

	a_qual_restart: assert property (@(posedge mclk) disable iff (!resetn)
		!ok |=> !done) else $error("qualification survived a dropped condition");
endmodule

// File: logic/hps_reg_if.sv
interface hps_reg_if;
	import hps_pkg::*;

	logic       seq_en;
	logic [2:0] retry;
	logic       por;
	logic       on_wr;
	logic       fault_wr;
	logic [3:0] wdata;
	logic [3:0] on_ctrl;
	logic [3:0] on_stat;
	logic [2:0] fault;
	hps_state_t st;
	logic       busy;
	logic       qualified;
	logic       pg_ok;

	modport regs (output seq_en, retry, on_wr, fault_wr, wdata,
		input por, on_ctrl, on_stat, fault, st, busy, qualified, pg_ok);
	modport core (input seq_en, retry, on_wr, fault_wr, wdata,
		output por, on_ctrl, on_stat, fault, st, busy, qualified, pg_ok);
endinterface

// File: logic/hps_sequencer.sv
// Summary of operation
// - Switches stay off until 100 ms qualification.
// - Supplies above lockout; negative check needs config low.
// - Set fault bits block start unless retry enabled.
// - Internal supply rising clears faults and controls.
// - Software may clear faults and set retry.
// - Pin high sets on bits, together or sequenced.
// - Otherwise start on pin rise or command.
// - Turn-on enables timer and soft-start sources.
// - Open-loop ramping amplifier slows soft-start current.
// - Ignore current limit while timer charges; discharge.
// - Cycle end resets soft-start, arms breaker.
// - Sequenced mode launches next supply's cycle.
// - Command mode idles until next command.
// - All on and good: power-good, follow bus reset.
// - Downstream timeout cycle, sample input at end.
// - Early insertion keeps switches off, reset asserted.
// - Still limiting at cycle end: off, fault, cool-down.
// - Downstream low logs fault; high enters run.
//
// The register addresses and register access over APB are this design's own decisions.
`include "hps_cfg.svh"

module hps_sequencer import hps_pkg::*; #(
	parameter int QUAL_CYCLES = `HPS_QUAL_CYCLES
) (
	input  wire logic        mclk,                    // System clock, 25 MHz.
	input  wire logic        resetn,                  // Synchronous reset, active low.
	input  wire logic        psel,                    // APB select.
	input  wire logic        penable,                 // APB access phase.
	input  wire logic        pwrite,                  // APB direction.
	input  wire logic [7:0]  paddr,                   // APB byte address.
	input  wire logic [31:0] pwdata,                  // APB write data.
	output logic      [31:0] prdata,                  // APB read data.
	output logic             pready,                  // APB ready.
	output logic             pslverr,                 // APB error.
	input  wire logic        board_select_n,          // Board select, low to allow power.
	input  wire logic        turn_on_pin,             // Turn-on pin.
	input  wire logic        internal_low_supply_ok,  // Internal supply above lockout.
	input  wire logic [2:0]  input_uv_ok,             // 12V, 5V, 3.3V above lockout.
	input  wire logic        vee_uv_ok,               // Negative supply above lockout.
	input  wire logic        cfg_tied_low,            // Supply configuration pin tied low.
	input  wire logic        supply_uv_event,         // Undervoltage seen while on.
	input  wire logic [3:0]  breaker_trip,            // Circuit breaker comparators.
	input  wire logic [3:0]  current_limit,           // Supply actively current limited.
	input  wire logic [3:0]  amp_open_loop,           // Limit amplifier open loop.
	input  wire logic        outputs_good,            // All outputs within tolerance.
	input  wire logic        downstream_good_in,      // Downstream good input.
	input  wire logic        pci_reset_n,             // Backplane bus reset, active low.
	input  wire logic        timer_hi,                // Timer reached its high level.
	input  wire logic        timer_lo,                // Timer below its low level.
	output logic      [3:0]  gate_on,                 // Gate drive enables.
	output logic      [3:0]  breaker_arm,             // Breaker armed, limit raised.
	output logic             timer_src_100u,          // Start-up timer source.
	output logic             timer_src_10u,           // Downstream timeout source.
	output logic             timer_src_2u,            // Cool-down source.
	output logic             timer_discharge,         // Timer switch to ground.
	output logic             ss_src_20u,              // Soft-start normal source.
	output logic             ss_src_2u,               // Soft-start slow source.
	output logic             ss_reset,                // Soft-start switch to ground.
	output logic             power_good_out_n,        // Power good, active low.
	output logic             local_bus_reset_n        // Local bus reset, active low.
);
	typedef struct packed {
		hps_state_t st;
		logic [3:0] on_ctrl;
		logic [3:0] on_stat;
		logic [3:0] ramping;
		logic [2:0] fault;
		logic       ivs_d;
		logic       pin_d;
		logic       qual_d;
		hps_out_t   out;
	} hps_seq_t;

	localparam hps_out_t OUT_RST = '{ss_rst: 1'b1, pg_n: 1'b1, default: '0};

	hps_seq_t s;
	hps_seq_t next_s;
	hps_reg_if rif ();
	logic qual_ok;
	logic qualified;
	logic stop_c;
	logic pg_ok;
	logic [3:0] pending;

	hps_apb_regs u_regs (
		.mclk    (mclk),
		.resetn  (resetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.rif     (rif.regs)
	);

	// Start conditions; board select is the backplane's final go-ahead.
	assign qual_ok = internal_low_supply_ok && (&input_uv_ok)
		&& (vee_uv_ok || !cfg_tied_low)
		&& !(|(s.fault & ~rif.retry))
		&& !board_select_n;

	hps_qual_timer #(
		.CYCLES (QUAL_CYCLES)
	) u_qual (
		.mclk   (mclk),
		.resetn (resetn),
		.ok     (qual_ok),
		.done   (qualified)
	);

	// Anything here forces every switch off at once.
	assign rif.por = internal_low_supply_ok && !s.ivs_d;
	// Board select is checked directly too, so removal does not wait for the qualifier.
	assign stop_c = !qualified || board_select_n || (s.pin_d && !turn_on_pin) || rif.por;
	assign pending = s.on_ctrl & ~s.on_stat;
	assign rif.on_ctrl = s.on_ctrl;
	assign rif.on_stat = s.on_stat;
	assign rif.fault = s.fault;
	assign rif.st = s.st;
	assign rif.busy = (s.st == HPS_RAMP_CHG) || (s.st == HPS_RAMP_DIS);
	assign rif.qualified = qualified;
	assign rif.pg_ok = !s.out.pg_n;

	// Sequencer: next state, on bits, faults and registered outputs.
	always_comb begin
		next_s = s;
		next_s.ivs_d = internal_low_supply_ok;
		next_s.pin_d = turn_on_pin;
		next_s.qual_d = qualified;
		// Clearing is allowed at any time; setting is blanked while ramping.
		if (rif.on_wr) begin
			next_s.on_ctrl = rif.busy ? (s.on_ctrl & rif.wdata) : rif.wdata;
			next_s.on_stat = s.on_stat & rif.wdata;
		end
		if (rif.fault_wr) begin
			next_s.fault = s.fault & rif.wdata[2:0];
			if (s.st == HPS_COOL_CHG || s.st == HPS_COOL_DIS) begin
				next_s.fault[`HPS_FLT_OC] = s.fault[`HPS_FLT_OC];
			end
		end
		// Pin high at qualification, or a later rising edge, starts turn-on.
		if (qualified && turn_on_pin && (!s.qual_d || !s.pin_d)) begin
			next_s.on_ctrl = rif.seq_en ? `HPS_FIRST_SEQ : `HPS_FIRST_ALL;
		end
		case (s.st)
			HPS_READY: begin
				if (qualified && |pending && !rif.on_wr) begin
					next_s.ramping = pending;
					next_s.st = HPS_RAMP_CHG;
				end else if (qualified && s.on_stat == 4'hF && outputs_good) begin
					next_s.st = HPS_PGI_CHG;
				end
			end
			HPS_RAMP_CHG: begin
				if (timer_hi) begin
					next_s.st = HPS_RAMP_DIS;
				end
			end
			HPS_RAMP_DIS: begin
				if (timer_lo) begin
					if (|(s.ramping & current_limit)) begin
						next_s.fault[`HPS_FLT_OC] = 1'b1;
						next_s.on_stat = 4'h0;
						next_s.st = HPS_COOL_CHG;
					end else begin
						next_s.on_stat = next_s.on_stat | s.ramping;
						if (rif.seq_en) begin
							next_s.on_ctrl = next_s.on_ctrl | {s.ramping[2:0], 1'b0};
						end
						next_s.st = HPS_READY;
					end
					next_s.ramping = 4'h0;
				end
			end
			HPS_PGI_CHG: begin
				if (timer_hi) begin
					next_s.st = HPS_PGI_DIS;
				end
			end
			HPS_PGI_DIS: begin
				if (timer_lo) begin
					if (downstream_good_in) begin
						next_s.st = HPS_RUN;
					end else begin
						next_s.fault[`HPS_FLT_PG] = 1'b1;
						next_s.on_stat = 4'h0;
						next_s.st = HPS_COOL_CHG;
					end
				end
			end
			HPS_RUN: begin
				if (next_s.on_stat != 4'hF) begin
					next_s.st = HPS_READY;
				end else if (!downstream_good_in) begin
					next_s.fault[`HPS_FLT_PG] = 1'b1;
					next_s.on_stat = 4'h0;
					next_s.st = HPS_COOL_CHG;
				end
			end
			HPS_COOL_CHG: begin
				if (timer_hi) begin
					next_s.st = HPS_COOL_DIS;
				end
			end
			HPS_COOL_DIS: begin
				if (timer_lo) begin
					next_s.st = HPS_READY;
				end
			end
			default: begin
				next_s.st = HPS_READY;
			end
		endcase
		// Breaker and undervoltage only count on supplies past their ramp.
		if (s.st != HPS_COOL_CHG && s.st != HPS_COOL_DIS) begin
			if (|(breaker_trip & s.on_stat)) begin
				next_s.fault[`HPS_FLT_OC] = 1'b1;
				next_s.on_stat = 4'h0;
				next_s.ramping = 4'h0;
				next_s.st = HPS_COOL_CHG;
			end else if (supply_uv_event && |s.on_stat) begin
				next_s.fault[`HPS_FLT_UV] = 1'b1;
				next_s.on_stat = 4'h0;
				next_s.ramping = 4'h0;
				next_s.st = HPS_COOL_CHG;
			end
		end
		// Losing a condition drops everything; sequencing restarts from 12V.
		if (stop_c) begin
			next_s.on_stat = 4'h0;
			next_s.ramping = 4'h0;
			if (next_s.st != HPS_COOL_CHG && next_s.st != HPS_COOL_DIS) begin
				next_s.st = HPS_READY;
			end
			if (s.pin_d && !turn_on_pin) begin
				next_s.on_ctrl = 4'h0;
			end else if (rif.seq_en) begin
				next_s.on_ctrl = next_s.on_ctrl & `HPS_FIRST_SEQ;
			end
		end
		if (rif.por) begin
			next_s.fault = 3'h0;
			next_s.on_ctrl = 4'h0;
			next_s.st = HPS_READY;
		end
		// Outputs follow the next state so each comes straight off a flop.
		next_s.out.gate_on = next_s.on_stat | next_s.ramping;
		next_s.out.breaker_arm = next_s.on_stat;
		next_s.out.tmr_100u = next_s.st == HPS_RAMP_CHG;
		next_s.out.tmr_10u = next_s.st == HPS_PGI_CHG;
		next_s.out.tmr_2u = next_s.st == HPS_COOL_CHG;
		next_s.out.tmr_dis = next_s.st inside {HPS_RAMP_DIS, HPS_PGI_DIS, HPS_COOL_DIS};
		next_s.out.ss_rst = !(next_s.st inside {HPS_RAMP_CHG, HPS_RAMP_DIS});
		next_s.out.ss_2u = !next_s.out.ss_rst && |(next_s.ramping & amp_open_loop);
		next_s.out.ss_20u = !next_s.out.ss_rst && !next_s.out.ss_2u;
		pg_ok = (next_s.st inside {HPS_PGI_CHG, HPS_PGI_DIS, HPS_RUN})
			&& next_s.on_stat == 4'hF && outputs_good;
		next_s.out.pg_n = !pg_ok;
		next_s.out.lrst_n = pg_ok && pci_reset_n;
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			s <= '{st: HPS_READY, out: OUT_RST, default: '0};
		end else begin
			s <= next_s;
		end
	end

	assign gate_on = s.out.gate_on;
	assign breaker_arm = s.out.breaker_arm;
	assign timer_src_100u = s.out.tmr_100u;
	assign timer_src_10u = s.out.tmr_10u;
	assign timer_src_2u = s.out.tmr_2u;
	assign timer_discharge = s.out.tmr_dis;
	assign ss_src_20u = s.out.ss_20u;
	assign ss_src_2u = s.out.ss_2u;
	assign ss_reset = s.out.ss_rst;
	assign power_good_out_n = s.out.pg_n;
	assign local_bus_reset_n = s.out.lrst_n;

	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);

	a_gates_off_unqual: assert property (!qualified |=> gate_on == 4'h0)
		else $error("gate on without qualification");
	a_early_insert: assert property (board_select_n |=> !local_bus_reset_n && gate_on == 4'h0)
		else $error("power or reset released before board select");
	a_ramp_sources: assert property (s.st == HPS_RAMP_CHG |-> timer_src_100u
		&& (ss_src_20u || ss_src_2u) && !ss_reset) else $error("ramp without sources");
	a_ss_slow: assert property (ss_src_2u |-> $past(|(next_s.ramping & amp_open_loop)))
		else $error("slow soft-start without open loop");
	a_ramp_discharge: assert property (s.st == HPS_RAMP_CHG && timer_hi && !stop_c
		|=> timer_discharge && !timer_src_100u) else $error("timer not discharged at high level");
	a_arm_at_end: assert property (s.st == HPS_RAMP_DIS && timer_lo && !stop_c
		&& !(|(s.ramping & current_limit)) && !(|(breaker_trip & s.on_stat))
		&& !(supply_uv_event && |s.on_stat) && !rif.on_wr
		|=> ss_reset && (breaker_arm & $past(s.ramping)) == $past(s.ramping))
		else $error("breaker not armed at cycle end");
	a_seq_next: assert property (rif.seq_en && s.st == HPS_RAMP_DIS && timer_lo && !stop_c
		&& s.ramping == 4'h1 && current_limit == 4'h0 && breaker_trip == 4'h0 && !rif.on_wr
		|=> s.on_ctrl[1] ##1 s.st == HPS_RAMP_CHG || stop_c || s.st == HPS_COOL_CHG)
		else $error("sequence did not advance");
	a_oc_log: assert property (s.st == HPS_RAMP_DIS && timer_lo && |(s.ramping & current_limit)
		&& !rif.por |=> s.fault[`HPS_FLT_OC] && gate_on == 4'h0 && timer_src_2u)
		else $error("overcurrent at cycle end not handled");
	a_pgi_fail: assert property (s.st == HPS_PGI_DIS && timer_lo && !downstream_good_in
		&& !rif.por |=> s.fault[`HPS_FLT_PG] && gate_on == 4'h0 && timer_src_2u)
		else $error("downstream fault not handled");
	a_bus_reset_follow: assert property (!power_good_out_n
		|-> local_bus_reset_n == $past(pci_reset_n)) else $error("local reset not following");
	a_por_clear: assert property (rif.por |=> s.fault == 3'h0 && s.on_ctrl == 4'h0)
		else $error("power-on reset did not clear");

	c_ramp_done: cover property (s.st == HPS_RAMP_DIS ##1 s.st == HPS_READY && |breaker_arm);
	c_run: cover property (s.st == HPS_PGI_DIS ##1 s.st == HPS_RUN);
	c_cool: cover property (s.st == HPS_COOL_DIS ##1 s.st == HPS_READY);
	c_seq_all: cover property (rif.seq_en && breaker_arm == 4'hF);
endmodule
